//--- rtl/poweron_status_regs.sv
// Power-on reset status flag bank behind a classic Wishbone slave.
// Assumes power-on pulses are synchronous one-or-more cycle levels.
// Functional notes
// - Writing one sets the supply power-on flag; writing zero leaves it.
// - Supply status clears only on supply power-on reset, survives others.
// - Supply flag reads one only if armed and no power-on since.
// - RTC power-on flag is set by writing one, cleared by zero.
// - RTC status clears only on RTC power-on reset or a zero write, survives other resets.
// - RTC flag reads one only if armed and no RTC power-on since.
`timescale 1ns/100ps
module poweron_status_regs
  import poweron_status_pkg::*;
(
  input  wire logic                                        ref_clk_i,
  input  wire logic                                        resetn_i,
  input  wire logic                                        por_pulse_i,
  input  wire logic                                        rtc_por_pulse_i,
  input  wire logic                                        wb_cyc_i,
  input  wire logic                                        wb_stb_i,
  input  wire logic                                        wb_we_i,
  input  wire logic [poweron_status_pkg::WB_ADDR_W-1:0]    wb_adr_i,
  input  wire logic [poweron_status_pkg::WB_SEL_W-1:0]     wb_sel_i,
  input  wire logic [poweron_status_pkg::WB_DATA_W-1:0]    wb_dat_i,
  output logic      [poweron_status_pkg::WB_DATA_W-1:0]    wb_dat_o,
  output logic                                             wb_ack_o,
  output logic                                             irq_o,
  output logic                                             poweron_seen_flag_o,
  output logic                                             rtc_poweron_seen_flag_o
);

  import poweron_status_pkg::*;

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  // Address match against one register
  function automatic logic reg_hit(input logic [WB_ADDR_W-1:0] adr,
                                   input logic [WB_ADDR_W-1:0] target);
    reg_hit = (adr == target);
  endfunction : reg_hit

  // Places a status byte in the low lane of a bus word
  function automatic logic [WB_DATA_W-1:0] low_lane(input logic [7:0] b);
    low_lane = {24'h00_0000, b};
  endfunction : low_lane

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  bus_state_t                 bus_state_reg;
  bus_state_t                 bus_state_next;
  logic [WB_DATA_W-1:0]       rdata_reg;
  logic [WB_DATA_W-1:0]       rdata_next;
  logic [IRQ_W-1:0]           irq_stat_reg;
  logic [IRQ_W-1:0]           irq_stat_next;
  logic [IRQ_W-1:0]           irq_mask_reg;
  logic [IRQ_W-1:0]           irq_mask_next;
  logic                       irq_reg;
  logic                       irq_next;

  wire                        req;
  wire                        req_start;
  wire                        commit;
  wire                        low_lane_wr;
  wire                        supply_hit;
  wire                        rtc_hit;
  wire                        stat_hit;
  wire                        mask_hit;
  wire                        supply_wr;
  wire                        rtc_wr;
  wire                        stat_wr;
  wire                        mask_wr;
  wire                        supply_flag;
  wire                        rtc_flag;
  wire                        supply_lost;
  wire                        rtc_lost;
  wire  [7:0]                 supply_byte;
  wire  [7:0]                 rtc_byte;
  wire  [IRQ_W-1:0]           irq_events;
  wire  [IRQ_W-1:0]           irq_w1c;
  wire  [WB_DATA_W-1:0]       rd_word;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // One hit line per mapped register
  assign supply_hit = reg_hit(wb_adr_i, SUPPLY_RST_ADDR);
  assign rtc_hit    = reg_hit(wb_adr_i, RTC_RST_ADDR);
  assign stat_hit   = reg_hit(wb_adr_i, IRQ_STAT_ADDR);
  assign mask_hit   = reg_hit(wb_adr_i, IRQ_MASK_ADDR);

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // Request accepted in idle, answered one cycle later
  assign req       = wb_cyc_i & wb_stb_i;
  assign req_start = req & (bus_state_reg == BUS_IDLE);
  // Writes land on the edge where the master sees ack
  assign commit      = req & wb_we_i & (bus_state_reg == BUS_ACK);
  assign low_lane_wr = commit & wb_sel_i[0];

  // Per-register write strobes
  assign supply_wr = low_lane_wr & supply_hit;
  assign rtc_wr    = low_lane_wr & rtc_hit;
  assign stat_wr   = low_lane_wr & stat_hit;
  assign mask_wr   = low_lane_wr & mask_hit;

  // Slave state sequencing
  always_comb begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      BUS_IDLE: begin
        if (req) begin
          bus_state_next = BUS_ACK;
        end
      end
      BUS_ACK: begin
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  assign wb_ack_o = (bus_state_reg == BUS_ACK);

  // ---------------------------------------------------------------
  // Power-on flag cells
  // ---------------------------------------------------------------
  // Supply flag: a zero write is ignored
  poweron_flag_cell #(
    .ZERO_CLEARS (1'b0)
  ) u_supply_flag (
    .ref_clk_i (ref_clk_i),
    .por_i     (por_pulse_i),
    .wr_i      (supply_wr),
    .wr_bit_i  (wb_dat_i[FLAG_BIT]),
    .flag_o    (supply_flag),
    .lost_o    (supply_lost)
  );

  // RTC flag: a zero write clears it
  poweron_flag_cell #(
    .ZERO_CLEARS (1'b1)
  ) u_rtc_flag (
    .ref_clk_i (ref_clk_i),
    .por_i     (rtc_por_pulse_i),
    .wr_i      (rtc_wr),
    .wr_bit_i  (wb_dat_i[FLAG_BIT]),
    .flag_o    (rtc_flag),
    .lost_o    (rtc_lost)
  );

  assign poweron_seen_flag_o     = supply_flag;
  assign rtc_poweron_seen_flag_o = rtc_flag;

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Upper bits of both status bytes are constant zero
  assign supply_byte = {7'h00, supply_flag};
  assign rtc_byte    = {7'h00, rtc_flag};

  // Read select; unmapped addresses read zero
  assign rd_word = supply_hit ? low_lane(supply_byte) :
                   rtc_hit    ? low_lane(rtc_byte) :
                   stat_hit   ? low_lane({6'h00, irq_stat_reg}) :
                   mask_hit   ? low_lane({6'h00, irq_mask_reg}) :
                   UNMAPPED_DATA;

  // Sampled at acceptance, held through the ack cycle
  assign rdata_next = (req_start && !wb_we_i) ? rd_word : rdata_reg;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rdata_reg <= UNMAPPED_DATA;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign wb_dat_o = rdata_reg;

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  // Armed flag wiped by its power-on pulse
  assign irq_events = {rtc_lost, supply_lost};
  assign irq_w1c    = stat_wr ? wb_dat_i[IRQ_W-1:0] : IRQ_STAT_RESET;

  // New event wins over a same-cycle clear
  assign irq_stat_next = (irq_stat_reg & ~irq_w1c) | irq_events;
  assign irq_mask_next = mask_wr ? wb_dat_i[IRQ_W-1:0] : irq_mask_reg;
  assign irq_next      = |(irq_stat_reg & irq_mask_reg);

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      irq_stat_reg <= IRQ_STAT_RESET;
      irq_mask_reg <= IRQ_MASK_RESET;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg      <= irq_next;
    end
  end

  assign irq_o = irq_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Read of one status register being accepted
  sequence s_supply_read;
    req_start && !wb_we_i && supply_hit;
  endsequence

  sequence s_rtc_read;
    req_start && !wb_we_i && rtc_hit;
  endsequence

  // Arm with no power-on pulse, then one more cycle without one
  sequence s_supply_armed;
    (supply_wr && wb_dat_i[FLAG_BIT] && !por_pulse_i) ##1 !por_pulse_i;
  endsequence

  a_supply_set_write: assert property (
    supply_wr && wb_dat_i[FLAG_BIT] && !por_pulse_i |=> supply_flag
  ) else $error("supply flag not set by a one write");

  a_supply_zero_keep: assert property (
    supply_wr && !wb_dat_i[FLAG_BIT] && !por_pulse_i |=> $stable(supply_flag)
  ) else $error("supply flag changed by a zero write");

  a_supply_por_clear: assert property (
    por_pulse_i |=> !supply_flag && (irq_stat_reg[IRQ_SUPPLY] || !$past(supply_flag))
  ) else $error("supply power-on pulse did not clear the flag");

  a_supply_other_hold: assert property (
    !por_pulse_i && !supply_wr |=> $stable(supply_flag)
  ) else $error("supply flag changed without write or power-on");

  a_supply_read_back: assert property (
    s_supply_read ##1 wb_ack_o |-> wb_dat_o[FLAG_BIT] == $past(supply_flag)
  ) else $error("supply flag read value wrong");

  a_supply_armed_reads: assert property (
    s_supply_armed |-> supply_flag
  ) else $error("armed supply flag lost without power-on");

  a_rtc_write_value: assert property (
    rtc_wr && !rtc_por_pulse_i |=> rtc_flag == $past(wb_dat_i[FLAG_BIT])
  ) else $error("rtc flag does not follow written bit");

  a_rtc_por_clear: assert property (
    rtc_por_pulse_i |=> !rtc_flag
  ) else $error("rtc power-on pulse did not clear the flag");

  a_rtc_core_immune: assert property (
    por_pulse_i && !rtc_por_pulse_i && !rtc_wr |=> $stable(rtc_flag)
  ) else $error("rtc flag disturbed by supply power-on");

  a_rtc_read_back: assert property (
    s_rtc_read |=> wb_ack_o && wb_dat_o[FLAG_BIT] == $past(rtc_flag)
  ) else $error("rtc flag read value wrong");

  a_status_upper_zero: assert property (
    s_supply_read or s_rtc_read |=> wb_dat_o[WB_DATA_W-1:1] == 31'h0000_0000
  ) else $error("status register upper bits not zero");

  a_ack_single_cycle: assert property (
    req_start |=> wb_ack_o ##1 !wb_ack_o
  ) else $error("ack not exactly one cycle after request");

  a_irq_follows_stat: assert property (
    |(irq_stat_reg & irq_mask_reg) |=> irq_o
  ) else $error("interrupt not raised for unmasked status");

  // Arm write accepted while the supply flag is still clear
  sequence s_supply_arm_accept;
    req_start && wb_we_i && supply_hit && wb_sel_i[0] &&
    wb_dat_i[FLAG_BIT] && !supply_flag;
  endsequence

  a_supply_arm_late: assert property (
    s_supply_arm_accept |=> !supply_flag
  ) else $error("supply flag set before the write was acknowledged");

  a_supply_por_wins: assert property (
    por_pulse_i && supply_wr |=> !supply_flag
  ) else $error("supply write beat a same-cycle power-on pulse");

  a_rtc_por_wins: assert property (
    rtc_por_pulse_i && rtc_wr |=> !rtc_flag
  ) else $error("rtc write beat a same-cycle rtc power-on pulse");

  a_rtc_other_hold: assert property (
    !rtc_por_pulse_i && !rtc_wr |=> $stable(rtc_flag)
  ) else $error("rtc flag changed without write or rtc power-on");

  a_sel_lane_only: assert property (
    commit && !wb_sel_i[0] && !por_pulse_i && !rtc_por_pulse_i
      |=> $stable(supply_flag) && $stable(rtc_flag)
  ) else $error("write without the low byte lane changed a flag");

  a_supply_event_sets: assert property (
    supply_lost |=> irq_stat_reg[IRQ_SUPPLY]
  ) else $error("lost supply flag did not set its status bit");

  a_rtc_event_sets: assert property (
    rtc_lost |=> irq_stat_reg[IRQ_RTC]
  ) else $error("lost rtc flag did not set its status bit");

  a_stat_w1c_clears: assert property (
    stat_wr && !(|irq_events) |=> (irq_stat_reg & $past(wb_dat_i[IRQ_W-1:0])) == IRQ_STAT_RESET
  ) else $error("status bit not cleared by a one write");

  a_mask_write_lands: assert property (
    mask_wr |=> irq_mask_reg == $past(wb_dat_i[IRQ_W-1:0])
  ) else $error("mask register does not hold the written value");

  a_irq_drops_idle: assert property (
    !(|(irq_stat_reg & irq_mask_reg)) |=> !irq_o
  ) else $error("interrupt high without an unmasked status bit");

  a_ack_needs_req: assert property (
    (bus_state_reg == BUS_IDLE) && !req |=> !wb_ack_o
  ) else $error("ack given without a request");

  a_rdata_holds: assert property (
    !(req_start && !wb_we_i) |=> $stable(wb_dat_o)
  ) else $error("read data changed without an accepted read");

endmodule : poweron_status_regs

//--- shared/poweron_status_pkg.sv
// Constants for the power-on reset status flag bank.
// Assumes a 32-bit classic Wishbone slave port with byte addresses.
package poweron_status_pkg;

  // ---------------------------------------------------------------
  // Bus widths
  // ---------------------------------------------------------------
  localparam int unsigned WB_ADDR_W = 24;
  localparam int unsigned WB_DATA_W = 32;
  localparam int unsigned WB_SEL_W  = 4;

  // ---------------------------------------------------------------
  // Register indexes; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [WB_ADDR_W-1:0] SUPPLY_RST_IDX = 24'h0f00f9;
  localparam logic [WB_ADDR_W-1:0] RTC_RST_IDX    = 24'h0f00fa;
  localparam logic [WB_ADDR_W-1:0] IRQ_STAT_IDX   = 24'h0f00fb;
  localparam logic [WB_ADDR_W-1:0] IRQ_MASK_IDX   = 24'h0f00fc;

  localparam logic [WB_ADDR_W-1:0] SUPPLY_RST_ADDR = {SUPPLY_RST_IDX[21:0], 2'b00};
  localparam logic [WB_ADDR_W-1:0] RTC_RST_ADDR    = {RTC_RST_IDX[21:0], 2'b00};
  localparam logic [WB_ADDR_W-1:0] IRQ_STAT_ADDR   = {IRQ_STAT_IDX[21:0], 2'b00};
  localparam logic [WB_ADDR_W-1:0] IRQ_MASK_ADDR   = {IRQ_MASK_IDX[21:0], 2'b00};

  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int unsigned FLAG_BIT      = 0;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic        FLAG_RESET    = STATUS_RESET[FLAG_BIT];
  localparam int unsigned IRQ_W         = 2;
  localparam int unsigned IRQ_SUPPLY    = 0;
  localparam int unsigned IRQ_RTC       = 1;
  localparam logic [IRQ_W-1:0] IRQ_STAT_RESET = 2'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [WB_DATA_W-1:0] UNMAPPED_DATA = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Bus slave states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

endpackage : poweron_status_pkg

//--- rtl/poweron_flag_cell.sv
// One power-on flag bit that no reset but its own power-on pulse clears.
// Assumes the pulse and the write strobe are synchronous to the clock.
`timescale 1ns/100ps
module poweron_flag_cell
  import poweron_status_pkg::*;
#(
  parameter bit ZERO_CLEARS = 1'b0
) (
  input  wire logic ref_clk_i,
  input  wire logic por_i,
  input  wire logic wr_i,
  input  wire logic wr_bit_i,
  output logic      flag_o,
  output logic      lost_o
);

  logic flag_reg;
  logic flag_next;

  // ---------------------------------------------------------------
  // Flag update
  // ---------------------------------------------------------------
  // Power-on pulse beats a write in the same cycle
  assign flag_next = por_i ? FLAG_RESET :
                     (wr_i && wr_bit_i) ? 1'b1 :
                     (wr_i && ZERO_CLEARS) ? 1'b0 :
                     flag_reg;

  // No ordinary reset here: the flag survives them
  always_ff @(posedge ref_clk_i) begin
    flag_reg <= flag_next;
  end

  // Armed flag wiped by a power-on pulse
  assign lost_o = por_i & flag_reg;
  assign flag_o = flag_reg;

endmodule : poweron_flag_cell

//--- verif/poweron_status_regs_tb.sv
// Self-checking bench for the power-on reset status flag bank.
// Assumes the design's Wishbone slave answers every request with one ack pulse.
`timescale 1ns/100ps
module poweron_status_regs_tb;
  import poweron_status_pkg::*;

  // ---------------------------------------------------------------
  // Signals and bookkeeping
  // ---------------------------------------------------------------
  localparam int LIMIT = 4000;
  logic                 ref_clk_i = 1'b0;
  logic                 resetn_i = 1'b0;
  logic                 por_pulse_i = 1'b1;
  logic                 rtc_por_pulse_i = 1'b1;
  logic                 wb_cyc_i = 1'b0;
  logic                 wb_stb_i = 1'b0;
  logic                 wb_we_i = 1'b0;
  logic [WB_ADDR_W-1:0] wb_adr_i = '0;
  logic [WB_SEL_W-1:0]  wb_sel_i = '0;
  logic [WB_DATA_W-1:0] wb_dat_i = '0;
  logic [WB_DATA_W-1:0] wb_dat_o;
  logic                 wb_ack_o;
  logic                 irq_o;
  logic                 poweron_seen_flag_o;
  logic                 rtc_poweron_seen_flag_o;
  logic [WB_DATA_W-1:0] exp_q[$];
  logic [WB_DATA_W-1:0] exp_d;
  logic [31:0]          rnd;
  int                   miscompares = 0;
  int                   num_checks = 0;
  int                   cycles = 0;

  `define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end

  poweron_status_regs u_dut (
    .ref_clk_i               (ref_clk_i),
    .resetn_i                (resetn_i),
    .por_pulse_i             (por_pulse_i),
    .rtc_por_pulse_i         (rtc_por_pulse_i),
    .wb_cyc_i                (wb_cyc_i),
    .wb_stb_i                (wb_stb_i),
    .wb_we_i                 (wb_we_i),
    .wb_adr_i                (wb_adr_i),
    .wb_sel_i                (wb_sel_i),
    .wb_dat_i                (wb_dat_i),
    .wb_dat_o                (wb_dat_o),
    .wb_ack_o                (wb_ack_o),
    .irq_o                   (irq_o),
    .poweron_seen_flag_o     (poweron_seen_flag_o),
    .rtc_poweron_seen_flag_o (rtc_poweron_seen_flag_o)
  );

  // ---------------------------------------------------------------
  // Clock, timeout and verdict
  // ---------------------------------------------------------------
  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // Cuts a hang short
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // Read monitor: oldest note against data returned with ack
  always @(posedge ref_clk_i) begin
    if (wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o === 1'b1) begin
      if (exp_q.size() == 0) `CHK("unexpected read", 1'b1, 1'b0)
      else begin
        exp_d = exp_q.pop_front();
        `CHK("read data", exp_d, wb_dat_o)
      end
    end
  end

  // ---------------------------------------------------------------
  // Bus and pulse tasks
  // ---------------------------------------------------------------
  // Single classic cycle, held until ack is sampled high
  task automatic xfer(input logic we, input logic [WB_ADDR_W-1:0] adr,
                      input logic [WB_DATA_W-1:0] dat, input logic [WB_SEL_W-1:0] sel);
    @(posedge ref_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : xfer

  // Byte-wide register write
  task automatic wr(input logic [WB_ADDR_W-1:0] adr, input logic [WB_DATA_W-1:0] dat);
    xfer(1'b1, adr, dat, 4'h1);
  endtask : wr

  task automatic rd(input logic [WB_ADDR_W-1:0] adr, input logic [WB_DATA_W-1:0] exp);
    exp_q.push_back(exp);
    xfer(1'b0, adr, 32'h0, 4'hf);
  endtask : rd

  // One-cycle power-on pulse, then time for flag and irq to settle
  task automatic pulse(input bit rtc);
    @(posedge ref_clk_i);
    if (rtc) rtc_por_pulse_i <= 1'b1;
    else por_pulse_i <= 1'b1;
    @(posedge ref_clk_i);
    rtc_por_pulse_i <= 1'b0;
    por_pulse_i     <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask : pulse

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rnd = $urandom(32'hac37);
    repeat (10) @(posedge ref_clk_i);
    resetn_i        <= 1'b1;
    por_pulse_i     <= 1'b0;
    rtc_por_pulse_i <= 1'b0;
    @(posedge ref_clk_i);
    rd(SUPPLY_RST_ADDR, 32'h0);
    rd(RTC_RST_ADDR, 32'h0);
    rd(IRQ_STAT_ADDR, 32'h0);
    rd(IRQ_MASK_ADDR, 32'h0);
    // Zero write and unselected byte leave the supply flag clear
    wr(SUPPLY_RST_ADDR, 32'hffff_fffe);
    xfer(1'b1, SUPPLY_RST_ADDR, 32'h1, 4'he);
    rd(SUPPLY_RST_ADDR, 32'h0);
    // Random data: only bit 0 counts, upper bits read zero
    for (int i = 0; i < 4; i++) begin
      rnd = $urandom;
      wr(SUPPLY_RST_ADDR, rnd | 32'h1);
      rd(SUPPLY_RST_ADDR, 32'h1);
      rnd = $urandom;
      wr(RTC_RST_ADDR, rnd);
      rd(RTC_RST_ADDR, {31'h0, rnd[0]});
    end
    wr(RTC_RST_ADDR, 32'h0000_00fe);
    rd(RTC_RST_ADDR, 32'h0);
    wr(RTC_RST_ADDR, 32'h1);
    wr(SUPPLY_RST_ADDR, 32'h0);
    rd(SUPPLY_RST_ADDR, 32'h1);
    `CHK("supply flag", 1'b1, poweron_seen_flag_o)
    `CHK("rtc flag", 1'b1, rtc_poweron_seen_flag_o)
    // Ordinary reset keeps both flags
    wr(IRQ_MASK_ADDR, 32'h3);
    @(posedge ref_clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    @(posedge ref_clk_i);
    rd(SUPPLY_RST_ADDR, 32'h1);
    rd(RTC_RST_ADDR, 32'h1);
    rd(IRQ_MASK_ADDR, 32'h0);
    rd(24'h000100, 32'h0);
    // RTC power-on with its event masked out
    wr(IRQ_MASK_ADDR, 32'h1);
    pulse(1'b1);
    `CHK("rtc flag after rtc por", 1'b0, rtc_poweron_seen_flag_o)
    `CHK("supply flag after rtc por", 1'b1, poweron_seen_flag_o)
    `CHK("irq masked", 1'b0, irq_o)
    rd(IRQ_STAT_ADDR, 32'h2);
    rd(RTC_RST_ADDR, 32'h0);
    // Supply power-on leaves the re-armed RTC flag alone
    wr(RTC_RST_ADDR, 32'h1);
    pulse(1'b0);
    `CHK("supply flag after por", 1'b0, poweron_seen_flag_o)
    `CHK("rtc flag after por", 1'b1, rtc_poweron_seen_flag_o)
    `CHK("irq raised", 1'b1, irq_o)
    rd(IRQ_STAT_ADDR, 32'h3);
    rd(SUPPLY_RST_ADDR, 32'h0);
    rd(RTC_RST_ADDR, 32'h1);
    // Write-one-to-clear drops the interrupt
    wr(IRQ_STAT_ADDR, 32'h1);
    repeat (2) @(posedge ref_clk_i);
    `CHK("irq cleared", 1'b0, irq_o)
    rd(IRQ_STAT_ADDR, 32'h2);
    wr(IRQ_STAT_ADDR, 32'h2);
    rd(IRQ_STAT_ADDR, 32'h0);
    // Power-on pulse in the cycle where an arming write lands: the pulse wins
    for (int k = 0; k < 2; k++) begin
      fork
        wr(k ? RTC_RST_ADDR : SUPPLY_RST_ADDR, 32'h1);
        begin
          @(posedge ref_clk_i);
          pulse(k == 1);
        end
      join
      rd(k ? RTC_RST_ADDR : SUPPLY_RST_ADDR, 32'h0);
    end
    rd(IRQ_STAT_ADDR, 32'h2);
    repeat (2) @(posedge ref_clk_i);
    `CHK("queue drained", 0, exp_q.size())
    tally_and_finish();
  end

endmodule : poweron_status_regs_tb
